// file: verilog/srbs_tap.sv
// Boundary-scan test access port of the burst SRAM
//
// Summary of operation
// - Sixteen-state controller, reset at power-up only.
// - No test multiplexer in pin-to-core paths.
// - Fixed lengths: 3, 1, 32, 109 bits.
// - Identification fields: revision, configuration, maker, one.
// - Code 001 selects the identification register.
// - Code 010 samples chain, outputs high impedance.
// - Code 100 samples chain, outputs stay functional.
// - Code 111 selects bypass, cleared to zero.
// - Bypass keeps last shifted bit after shift.
// - External test, control cell clear: outputs off.
// - External test, control cell set: drive sampled values.
// - Output transfer happens at update-instruction state.
// - Control cell is position 109, scan-loaded only.
// - Serial input feeds first stage of chain.
// - Unconnected pin positions are don't-care values.
// - Serial output changes on falling test clock.
`timescale 1ns/100ps
module srbs_tap
    import srbs_pkg::*;
#(
    parameter logic [2:0]  ID_REV = 3'h0,     // Arbitrary revision
    parameter logic [16:0] ID_CFG = 17'h0ABCD, // Arbitrary value
    parameter logic [10:0] ID_MFR = 11'h2A5    // Arbitrary value
) (
    input  wire logic                  clock,     // Memory core clock
    input  wire logic                  rst_b,     // Power-up reset
    input  wire logic                  tck,       // Test clock
    input  wire logic                  tms,       // Test mode select
    input  wire logic                  tdi,       // Serial data in
    output logic                       tdo,       // Serial data out
    output logic                       tdo_oe,    // Serial out enable
    input  wire logic [SRBS_PIN_W-1:0] pin_in,    // Observed pin levels
    input  wire logic [SRBS_Q_W-1:0]   q_func,    // Core read data
    input  wire logic                  q_func_oe, // Core output enable
    output logic      [SRBS_Q_W-1:0]   q_out,     // Data output pins
    output logic                       q_oe       // Data output enable
);

    ////////////////////////////////////////////////////////////////////////
    // State of the test clock domain
    typedef struct packed {
        srbs_state_e               st;     // Controller state
        logic [SRBS_IR_W-1:0]      instr;  // Active instruction
        logic [SRBS_IR_W-1:0]      ir_sh;  // Instruction shift stage
        logic                      byp;    // Bypass stage
        logic                      ictl;   // Internal control latch
        logic                      hiz;    // Outputs forced off
        logic                      drv;    // Outputs driven by scan
        logic [SRBS_ID_W-1:0]      id_sh;  // Identification shifter
        logic [SRBS_BSR_W-1:0]     bsr;    // Boundary chain
        logic [SRBS_Q_W-1:0]       q_upd;  // Values for the outputs
    } srbs_tck_s;

    // Falling-edge output stage
    typedef struct packed {
        logic tdo;  // Serial output bit
        logic oe;   // Serial output enable
    } srbs_tdo_s;

    // State of the core clock domain
    typedef struct packed {
        logic                hiz_d;  // Settled off request
        logic                drv_d;  // Settled drive request
        logic [SRBS_Q_W-1:0] q_out;  // Registered output data
        logic                q_oe;   // Registered output enable
    } srbs_clk_s;

    srbs_tck_s             tck_ff;   // Test clock state
    srbs_tck_s             nxt_tck;  // Its next value
    srbs_tdo_s             tdo_ff;   // Serial output state
    srbs_tdo_s             nxt_tdo;  // Its next value
    srbs_clk_s             clk_ff;   // Core clock state
    srbs_clk_s             nxt_clk;  // Its next value
    logic [SRBS_PIN_W-1:0] pin_s;    // Pins in test clock domain
    logic [SRBS_Q_W+1:0]   xfer_s;   // Requests in core domain
    logic [SRBS_ID_W-1:0]  id_val;   // Identification value
    logic                  sel_id;   // Identification selected
    logic                  sel_bsr;  // Boundary chain selected
    logic                  is_shift; // In a shift state

    ////////////////////////////////////////////////////////////////////////
    // Standard controller graph on mode select
    function automatic srbs_state_e srbs_next(srbs_state_e s, logic m);
        case (s)
            SRBS_TLR:    return m ? SRBS_TLR    : SRBS_RTI;
            SRBS_RTI:    return m ? SRBS_SEL_DR : SRBS_RTI;
            SRBS_SEL_DR: return m ? SRBS_SEL_IR : SRBS_CAP_DR;
            SRBS_CAP_DR: return m ? SRBS_EX1_DR : SRBS_SH_DR;
            SRBS_SH_DR:  return m ? SRBS_EX1_DR : SRBS_SH_DR;
            SRBS_EX1_DR: return m ? SRBS_UPD_DR : SRBS_PAU_DR;
            SRBS_PAU_DR: return m ? SRBS_EX2_DR : SRBS_PAU_DR;
            SRBS_EX2_DR: return m ? SRBS_UPD_DR : SRBS_SH_DR;
            SRBS_UPD_DR: return m ? SRBS_SEL_DR : SRBS_RTI;
            SRBS_SEL_IR: return m ? SRBS_TLR    : SRBS_CAP_IR;
            SRBS_CAP_IR: return m ? SRBS_EX1_IR : SRBS_SH_IR;
            SRBS_SH_IR:  return m ? SRBS_EX1_IR : SRBS_SH_IR;
            SRBS_EX1_IR: return m ? SRBS_UPD_IR : SRBS_PAU_IR;
            SRBS_PAU_IR: return m ? SRBS_EX2_IR : SRBS_PAU_IR;
            SRBS_EX2_IR: return m ? SRBS_UPD_IR : SRBS_SH_IR;
            default:     return m ? SRBS_SEL_DR : SRBS_RTI;
        endcase
    endfunction : srbs_next

    ////////////////////////////////////////////////////////////////////////
    // Pins pass two test clock flops before capture
    srbs_sync #(.W(SRBS_PIN_W)) u_pin_sync (
        .clock (tck),
        .rst_b (rst_b),
        .d     (pin_in),
        .q     (pin_s)
    );

    // Identification word; constant start bit at bit 0
    assign id_val = {ID_REV, ID_CFG, ID_MFR, SRBS_ID_START};

    // Register selection; reserved codes fall to bypass
    assign sel_id  = (tck_ff.instr == SRBS_OP_IDCODE);
    assign sel_bsr = (tck_ff.instr == SRBS_OP_EXTEST)
                  || (tck_ff.instr == SRBS_OP_SAMPLEZ)
                  || (tck_ff.instr == SRBS_OP_SAMPLE);

    ////////////////////////////////////////////////////////////////////////
    // Controller and scan registers, rising test clock
    always_comb
    begin
        nxt_tck    = tck_ff;
        nxt_tck.st = srbs_next(tck_ff.st, tms);
        case (tck_ff.st)
            // Reset selects identification read
            SRBS_TLR:
            begin
                nxt_tck.instr = SRBS_IR_RST;
            end
            // Instruction capture pattern
            SRBS_CAP_IR:
            begin
                nxt_tck.ir_sh = SRBS_IR_CAPT;
            end
            // Instruction shift, least bit out first
            SRBS_SH_IR:
            begin
                nxt_tck.ir_sh = {tdi, tck_ff.ir_sh[SRBS_IR_W-1:1]};
            end
            // New instruction takes effect
            SRBS_UPD_IR:
            begin
                nxt_tck.instr = tck_ff.ir_sh;
                if (tck_ff.ir_sh == SRBS_OP_BYPASS)
                    nxt_tck.byp = SRBS_BYP_RST;
                if (tck_ff.ir_sh == SRBS_OP_EXTEST)
                    nxt_tck.q_upd = tck_ff.bsr[SRBS_Q_BASE +: SRBS_Q_W];
            end
            // Parallel capture into selected register
            SRBS_CAP_DR:
            begin
                if (sel_id)
                    nxt_tck.id_sh = id_val;
                else if (sel_bsr)
                    nxt_tck.bsr = {tck_ff.ictl, pin_s};
                else
                    nxt_tck.byp = SRBS_BYP_RST;
            end
            // Serial shift of selected register
            SRBS_SH_DR:
            begin
                if (sel_id)
                    nxt_tck.id_sh = {tdi, tck_ff.id_sh[SRBS_ID_W-1:1]};
                else if (sel_bsr)
                    nxt_tck.bsr = {tck_ff.bsr[SRBS_BSR_W-2:0], tdi};
                else
                    nxt_tck.byp = tdi;
            end
            // Control cell loads from the chain only here
            SRBS_UPD_DR:
            begin
                if ((tck_ff.instr == SRBS_OP_EXTEST)
                    || (tck_ff.instr == SRBS_OP_SAMPLE))
                    nxt_tck.ictl = tck_ff.bsr[SRBS_ICTL];
            end
            default:
            begin
            end
        endcase
        // Output mode derived from next instruction value
        nxt_tck.hiz = (nxt_tck.instr == SRBS_OP_SAMPLEZ)
                   || ((nxt_tck.instr == SRBS_OP_EXTEST)
                       && !nxt_tck.ictl);
        nxt_tck.drv = (nxt_tck.instr == SRBS_OP_EXTEST)
                   && nxt_tck.ictl;
    end

    // Power-up reset only; there is no test reset pin
    always_ff @(posedge tck or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tck_ff       <= '0;
            tck_ff.st    <= SRBS_TLR;
            tck_ff.instr <= SRBS_IR_RST;
            tck_ff.byp   <= SRBS_BYP_RST;
            tck_ff.ictl  <= SRBS_ICTL_RST;
        end
        else
            tck_ff <= nxt_tck;
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial output, changed on the falling test clock
    assign is_shift = (tck_ff.st == SRBS_SH_IR)
                   || (tck_ff.st == SRBS_SH_DR);

    always_comb
    begin
        nxt_tdo    = tdo_ff;
        nxt_tdo.oe = is_shift;
        if (tck_ff.st == SRBS_SH_IR)
            nxt_tdo.tdo = tck_ff.ir_sh[0];
        else if (sel_id)
            nxt_tdo.tdo = tck_ff.id_sh[0];
        else if (sel_bsr)
            nxt_tdo.tdo = tck_ff.bsr[SRBS_BSR_W-1];
        else
            nxt_tdo.tdo = tck_ff.byp;
    end

    // Falling-edge register
    always_ff @(negedge tck or negedge rst_b)
    begin
        if (!rst_b)
            tdo_ff <= '0;
        else
            tdo_ff <= nxt_tdo;
    end

    assign tdo    = tdo_ff.tdo;
    assign tdo_oe = tdo_ff.oe;

    ////////////////////////////////////////////////////////////////////////
    // Output mode and values cross into the core clock
    srbs_sync #(.W(SRBS_Q_W + 2)) u_mode_sync (
        .clock (clock),
        .rst_b (rst_b),
        .d     ({tck_ff.drv, tck_ff.hiz, tck_ff.q_upd}),
        .q     (xfer_s)
    );

    // Output stage; mode delayed one cycle so data settles first
    always_comb
    begin
        nxt_clk       = clk_ff;
        nxt_clk.hiz_d = xfer_s[SRBS_Q_W];
        nxt_clk.drv_d = xfer_s[SRBS_Q_W+1];
        if (clk_ff.drv_d)
        begin
            nxt_clk.q_out = xfer_s[SRBS_Q_W-1:0];
            nxt_clk.q_oe  = 1'h1;
        end
        else
        begin
            nxt_clk.q_out = q_func;
            nxt_clk.q_oe  = q_func_oe && !clk_ff.hiz_d;
        end
    end

    // Core clock registers; input pins never pass through here
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            clk_ff <= '0;
        else
            clk_ff <= nxt_clk;
    end

    assign q_out = clk_ff.q_out;
    assign q_oe  = clk_ff.q_oe;

    ////////////////////////////////////////////////////////////////////////
    // Checks in the test clock domain
    AST_RESET_ID: assert property (@(posedge tck) disable iff (!rst_b)
        (tck_ff.st == SRBS_TLR) |=> (tck_ff.instr == SRBS_OP_IDCODE))
        else $error("instruction not identification after reset");

    AST_TMS_FIVE: assert property (@(posedge tck) disable iff (!rst_b)
        tms [*5] |=> (tck_ff.st == SRBS_TLR))
        else $error("five mode-select highs did not reach reset");

    AST_TDO_OE: assert property (@(posedge tck) disable iff (!rst_b)
        tdo_oe == is_shift)
        else $error("serial output enable outside shift states");

    AST_BYP_CLEAR: assert property (@(posedge tck) disable iff (!rst_b)
        (tck_ff.st == SRBS_UPD_IR && tck_ff.ir_sh == SRBS_OP_BYPASS)
        |=> !tck_ff.byp)
        else $error("bypass stage not cleared");

    AST_BYP_HOLD: assert property (@(posedge tck) disable iff (!rst_b)
        (tck_ff.st == SRBS_SH_DR && tck_ff.instr == SRBS_OP_BYPASS)
        |=> (tck_ff.byp == $past(tdi)))
        else $error("bypass stage lost last shifted bit");

    AST_ID_START: assert property (@(posedge tck) disable iff (!rst_b)
        (tck_ff.st == SRBS_CAP_DR && sel_id) |=> tck_ff.id_sh[0])
        else $error("identification start bit not one");

    AST_XFER: assert property (@(posedge tck) disable iff (!rst_b)
        (tck_ff.st == SRBS_UPD_IR && tck_ff.ir_sh == SRBS_OP_EXTEST)
        |=> (tck_ff.q_upd == $past(tck_ff.bsr[SRBS_Q_W-1:0])))
        else $error("output values not transferred at update");

    AST_ICTL_LOCK: assert property (@(posedge tck) disable iff (!rst_b)
        (tck_ff.instr != SRBS_OP_EXTEST && tck_ff.instr != SRBS_OP_SAMPLE)
        |=> $stable(tck_ff.ictl))
        else $error("control cell changed under wrong instruction");

    AST_TDI_FIRST: assert property (@(posedge tck) disable iff (!rst_b)
        (tck_ff.st == SRBS_SH_DR && sel_bsr) |=> (tck_ff.bsr[0] == $past(tdi)))
        else $error("serial input not in first chain stage");

    // Checks in the core clock domain
    AST_OUT_OFF: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_ff.hiz_d && !clk_ff.drv_d) |=> !q_oe)
        else $error("outputs not off under off request");

    AST_OUT_DRIVE: assert property (@(posedge clock) disable iff (!rst_b)
        clk_ff.drv_d |=> (q_oe && q_out == $past(xfer_s[SRBS_Q_W-1:0])))
        else $error("outputs not driven with scan values");

    AST_OUT_FUNC: assert property (@(posedge clock) disable iff (!rst_b)
        (!clk_ff.drv_d && !clk_ff.hiz_d)
        |=> (q_oe == $past(q_func_oe) && q_out == $past(q_func)))
        else $error("functional outputs disturbed");

    // Main scenarios
    COV_IDREAD: cover property (@(posedge tck) disable iff (!rst_b)
        tck_ff.st == SRBS_SH_DR && sel_id);
    COV_BYPASS: cover property (@(posedge tck) disable iff (!rst_b)
        tck_ff.st == SRBS_SH_DR && tck_ff.instr == SRBS_OP_BYPASS);
    COV_EXT_DRIVE: cover property (@(posedge clock) disable iff (!rst_b)
        clk_ff.drv_d && q_oe);
    COV_SAMPLEZ: cover property (@(posedge tck) disable iff (!rst_b)
        tck_ff.instr == SRBS_OP_SAMPLEZ && tck_ff.st == SRBS_CAP_DR);

endmodule : srbs_tap

// file: shared/srbs_pkg.sv
// Constants and types shared by the boundary-scan port of the burst SRAM
package srbs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Scan register lengths
    localparam int SRBS_IR_W   = 3;    // Instruction register bits
    localparam int SRBS_ID_W   = 32;   // Identification register bits
    localparam int SRBS_BSR_W  = 109;  // Boundary chain positions
    localparam int SRBS_PIN_W  = 108;  // Pin cells, positions 1 to 108
    localparam int SRBS_Q_W    = 36;   // Memory data outputs
    localparam int SRBS_Q_BASE = 0;    // Chain index of first output cell
    localparam int SRBS_ICTL   = 108;  // Chain index of internal cell

    ////////////////////////////////////////////////////////////////////////
    // Instruction codes
    localparam logic [2:0] SRBS_OP_EXTEST  = 3'h0;  // External test
    localparam logic [2:0] SRBS_OP_IDCODE  = 3'h1;  // Identification read
    localparam logic [2:0] SRBS_OP_SAMPLEZ = 3'h2;  // Sample, outputs off
    localparam logic [2:0] SRBS_OP_SAMPLE  = 3'h4;  // Plain sample
    localparam logic [2:0] SRBS_OP_BYPASS  = 3'h7;  // Bypass stage
    localparam logic [2:0] SRBS_IR_CAPT    = 3'h1;  // Instruction capture
    localparam logic [2:0] SRBS_IR_RST     = 3'h1;  // Active after reset

    ////////////////////////////////////////////////////////////////////////
    // Identification field positions and fixed values
    localparam int SRBS_ID_REV_LSB = 29;  // Revision, bits 31..29
    localparam int SRBS_ID_CFG_LSB = 12;  // Configuration, bits 28..12
    localparam int SRBS_ID_MFR_LSB = 1;   // Maker code, bits 11..1
    localparam logic SRBS_ID_START = 1'h1; // Constant bit 0

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic SRBS_BYP_RST  = 1'h0;  // Bypass stage
    localparam logic SRBS_ICTL_RST = 1'h0;  // Internal control cell

    // Test access controller states
    typedef enum logic [3:0] {
        SRBS_TLR, SRBS_RTI, SRBS_SEL_DR, SRBS_CAP_DR, SRBS_SH_DR,
        SRBS_EX1_DR, SRBS_PAU_DR, SRBS_EX2_DR, SRBS_UPD_DR,
        SRBS_SEL_IR, SRBS_CAP_IR, SRBS_SH_IR, SRBS_EX1_IR,
        SRBS_PAU_IR, SRBS_EX2_IR, SRBS_UPD_IR
    } srbs_state_e;

endpackage : srbs_pkg

// file: verilog/srbs_sync.sv
// Two-flop level synchroniser, parameterised in width
`timescale 1ns/100ps
module srbs_sync #(
    parameter int W = 1  // Bits carried
) (
    input  wire logic         clock,  // Destination clock
    input  wire logic         rst_b,  // Asynchronous reset, active low
    input  wire logic [W-1:0] d,      // Level from the other domain
    output logic      [W-1:0] q       // Synchronised level
);

    // Both stages in one state word
    typedef struct packed {
        logic [W-1:0] meta;  // First stage, read only by second
        logic [W-1:0] sync;  // Second stage
    } srbs_sync_s;

    srbs_sync_s sync_ff;   // Registered state
    srbs_sync_s nxt_sync;  // Next state

    ////////////////////////////////////////////////////////////////////////
    // Shift the level through two stages
    always_comb
    begin
        nxt_sync      = sync_ff;
        nxt_sync.meta = d;
        nxt_sync.sync = sync_ff.meta;
    end

    // Register the stages
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            sync_ff <= '0;
        else
            sync_ff <= nxt_sync;
    end

    assign q = sync_ff.sync;

endmodule : srbs_sync

// file: test/srbs_jtag_host.sv
// Model of the external controller that drives the test access port
`timescale 1ns/100ps
module srbs_jtag_host (
    output logic      tck,  // Test clock, still between frames
    output logic      tms,  // Mode select
    output logic      tdi,  // Serial data towards the port
    input  wire logic tdo   // Serial data from the port
);

    ////////////////////////////////////////////////////////////////////////
    // Idle levels from time zero
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One 12 ns test clock cycle; returns the serial out seen at the rise
    task automatic step(input logic m, input logic d, output logic s);
    begin
        tms = m;
        tdi = d;
        #6;
        tck = 1'h1;
        s   = tdo;
        #6;
        tck = 1'h0;
    end
    endtask : step

    // Five mode-select highs, then park in run-test/idle
    task automatic reset5;
        logic s;
    begin
        repeat (5) step(1'h1, ~tdi, s);
        step(1'h0, ~tdi, s);
    end
    endtask : reset5

    // Full scan frame from idle to idle, bits LSB first
    task automatic scan(input logic ir, input int n,
                        input logic [108:0] din, output logic [108:0] dout);
        logic         s;
        logic [108:0] v;  // Bits actually sent
    begin
        dout = '0;
        v    = din;
        // Reserved instruction codes are never loaded; bypass instead
        if (ir && ((din[2:0] == 3'h3) || (din[2:0] == 3'h5)
                   || (din[2:0] == 3'h6)))
            v = 109'h7;
        step(1'h1, ~tdi, s);
        if (ir)
            step(1'h1, ~tdi, s);
        step(1'h0, ~tdi, s);
        step(1'h0, ~tdi, s);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, v[i], s);
            dout[i] = s;
        end
        step(1'h1, ~tdi, s);
        step(1'h0, ~tdi, s);
    end
    endtask : scan

endmodule : srbs_jtag_host

// file: test/srbs_tap_bench.sv
// Self-checking bench of the boundary-scan test access port
`timescale 1ns/100ps
module srbs_tap_bench;
    import srbs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Identification values, all arbitrary
    localparam logic [2:0]  REV = 3'h5;
    localparam logic [16:0] CFG = 17'h1C3A5;
    localparam logic [10:0] MFR = 11'h15A;
    localparam logic [35:0] QPAT = 36'h9E1C3A5B7;  // Output cell pattern

    logic           clock;      // Core clock
    logic           rst_b;      // Power-up reset
    logic           tck;        // Test clock
    logic           tms;        // Mode select
    logic           tdi;        // Serial in
    logic           tdo;        // Serial out
    logic           tdo_oe;     // Serial out enable
    logic [107:0]   pin_in;     // Observed pins
    logic [35:0]    q_func;     // Core data
    logic           q_func_oe;  // Core enable
    logic [35:0]    q_out;      // Output pins
    logic           q_oe;       // Output enable
    logic [108:0]   d;          // Shifted-out bits
    int             fails;      // Mismatches
    int             n_compared; // Comparisons

    srbs_tap #(.ID_REV(REV), .ID_CFG(CFG), .ID_MFR(MFR)) i_srbs_tap (
        .clock(clock), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .q_func(q_func),
        .q_func_oe(q_func_oe), .q_out(q_out), .q_oe(q_oe));

    srbs_jtag_host i_srbs_jtag_host (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    ////////////////////////////////////////////////////////////////////////
    // Core clock
    initial
    begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end

    // Vector compare
    task automatic cmp(input logic [108:0] got, input logic [108:0] exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask : cmp

    // Verdict and end of run
    task automatic stop_test;
    begin
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask : stop_test

    // Bit order reversal for chain load and unload
    function automatic logic [108:0] rev(input logic [108:0] v);
        logic [108:0] r;
        for (int i = 0; i < 109; i++)
            r[i] = v[108 - i];
        return r;
    endfunction : rev

    // Let the output mode cross into the core domain
    task automatic settle;
    begin
        repeat (12) @(posedge clock);
        @(negedge clock);
    end
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    // Identification read straight after reset, 33rd bit is serial in
    task automatic t_id;
    begin
        cmp(109'(tdo_oe), 109'h0);
        // Controller starts in reset; park in run-test/idle first
        i_srbs_jtag_host.reset5();
        i_srbs_jtag_host.scan(1'h0, 33, 109'h1, d);
        cmp(d, {77'h1, REV, CFG, MFR, 1'h1});
        cmp(109'(tdo_oe), 109'h0);
    end
    endtask : t_id

    // Bypass stage starts at zero and delays by one bit
    task automatic t_bypass;
    begin
        i_srbs_jtag_host.scan(1'h1, 3, 109'(SRBS_OP_BYPASS), d);
        cmp(d, 109'h1);
        i_srbs_jtag_host.scan(1'h0, 4, 109'hB, d);
        cmp(d, 109'h6);
    end
    endtask : t_bypass

    // Sample, load pattern and control bit, then external test drives it
    task automatic t_sample_extest;
    begin
        i_srbs_jtag_host.scan(1'h1, 3, 109'(SRBS_OP_SAMPLE), d);
        settle();
        cmp(109'(q_oe), 109'(q_func_oe));
        cmp(109'(q_out), 109'(q_func));
        i_srbs_jtag_host.scan(1'h0, 109, rev({1'h1, 72'h0, QPAT}), d);
        cmp(rev(d), {1'h0, pin_in});
        i_srbs_jtag_host.scan(1'h1, 3, 109'(SRBS_OP_EXTEST), d);
        settle();
        cmp(109'(q_oe), 109'h1);
        cmp(109'(q_out), 109'(QPAT));
        i_srbs_jtag_host.scan(1'h0, 109, rev({1'h0, 72'h0, QPAT}), d);
        cmp(109'(d[0]), 109'h1);
        settle();
        cmp(109'(q_oe), 109'h0);
    end
    endtask : t_sample_extest

    // High-impedance sample turns the outputs off
    task automatic t_hiz;
    begin
        i_srbs_jtag_host.scan(1'h1, 3, 109'(SRBS_OP_SAMPLEZ), d);
        settle();
        cmp(109'(q_oe), 109'h0);
        i_srbs_jtag_host.scan(1'h0, 109, 109'h0, d);
        cmp(rev(d), {1'h0, pin_in});
    end
    endtask : t_hiz

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        fails = 0;
        n_compared = 0;
        rst_b = 1'h0;
        pin_in = 108'h0;
        q_func = 36'h0;
        q_func_oe = 1'h0;
        repeat (8) @(posedge clock);
        rst_b <= 1'h1;
        pin_in <= {27{4'hC}} ^ 108'h5A3;
        q_func <= 36'h123456789;
        q_func_oe <= 1'h1;
        @(posedge clock);
        t_id();
        i_srbs_jtag_host.reset5();
        t_bypass();
        t_sample_extest();
        t_hiz();
        stop_test();
    end

    // Cut a hang short
    initial
    begin
        #100000;
        fails++;
        stop_test();
    end

endmodule : srbs_tap_bench
